// file: bench/slirq_top_chk.sv
// Port-level checker for the serial-link interrupt block
`timescale 1ns/10ps
`include "slirq_consts.svh"
module slirq_top_chk
	import slirq_pkg::*;
#(
	parameter int NUM_LINKS = 2,
	parameter int LINK_W = 1,
	parameter int LANE_W = 3,
	parameter int IDX_W = 4
)(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire slirq_addr_t reg_addr,
	input wire slirq_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire slirq_byte_t reg_rdata,
	input wire logic [NUM_LINKS*`SLIRQ_EXT_EVENTS-1:0] link_events,
	input wire logic ilas_valid,
	input wire logic [LINK_W-1:0] ilas_link,
	input wire logic [LANE_W-1:0] ilas_lane,
	input wire logic [IDX_W-1:0] ilas_idx,
	input wire slirq_byte_t ilas_byte,
	input wire logic irq_pin_first,
	input wire logic irq_pin_second_n
);
	logic sel;
	// Shadow of the global pin select, so routing is judged without peeking inside
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) sel <= 1'b0;
		else if (reg_wr && reg_addr == `SLIRQ_ADDR_PIN_SEL) sel <= reg_wdata[0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence sel_wr_s; reg_wr && reg_addr == `SLIRQ_ADDR_PIN_SEL; endsequence
	sequence sel_rd_s; reg_rd && !reg_wr && reg_addr == `SLIRQ_ADDR_PIN_SEL; endsequence
	sel_readback_a: assert property (sel_wr_s ##1 !reg_wr ##1 sel_rd_s |=>
		reg_rdata == ($past(reg_wdata, 3) & 8'h01)) else $error("pin select readback");
	route_first_a: assert property (!$past(sel) |-> irq_pin_second_n)
		else $error("second pin active while first chosen");
	route_second_a: assert property ($past(sel) |-> !irq_pin_first)
		else $error("first pin active while second chosen");
	stat_b_rsvd_a: assert property (reg_rd && reg_addr == `SLIRQ_ADDR_ST_B |=>
		reg_rdata[7:1] == 7'h00) else $error("status B reserved bits set");
	pin_sel_rsvd_a: assert property (reg_rd && reg_addr == `SLIRQ_ADDR_PIN_SEL |=>
		reg_rdata[7:1] == 7'h00) else $error("pin select reserved bits set");
	page_width_a: assert property (reg_rd && reg_addr == `SLIRQ_ADDR_PAGE |=>
		reg_rdata[7:LINK_W] == '0) else $error("page register too wide");
	unmapped_zero_a: assert property (reg_rd && reg_addr == 12'h44f |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
endmodule : slirq_top_chk
bind slirq_top slirq_top_chk #(.NUM_LINKS(NUM_LINKS), .LINK_W(LINK_W), .LANE_W(LANE_W),
	.IDX_W(IDX_W)) u_chk (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .link_events, .ilas_valid, .ilas_link, .ilas_lane, .ilas_idx, .ilas_byte,
	.irq_pin_first, .irq_pin_second_n);

// file: bench/slirq_tx_model.sv
// Link transmitter model: alignment-data bytes and per-link event pulses
`timescale 1ns/10ps
`include "slirq_consts.svh"
module slirq_tx_model
	import slirq_pkg::*;
(
	input wire logic clk_sys,
	output logic [2*`SLIRQ_EXT_EVENTS-1:0] link_events,
	output logic ilas_valid,
	output logic [0:0] ilas_link,
	output logic [2:0] ilas_lane,
	output logic [3:0] ilas_idx,
	output slirq_byte_t ilas_byte
);
	// Quiet link at time zero
	initial begin
		link_events = '0;
		ilas_valid = 1'b0;
		ilas_link = 1'b0;
		ilas_lane = 3'h0;
		ilas_idx = 4'h0;
		ilas_byte = 8'h00;
	end
	// One-cycle pulse of one event source
	task automatic ev(input int link, input int b);
		@(posedge clk_sys);
		link_events[link*`SLIRQ_EXT_EVENTS+b] <= 1'b1;
		@(posedge clk_sys);
		link_events <= '0;
	endtask : ev
	// Sequence of 14 bytes; flip corrupts one byte, the checksum follows what was sent
	task automatic send(input logic lnk, input logic [2:0] lane, input slirq_byte_t base,
		input int flip);
		slirq_byte_t sum;
		slirq_byte_t b;
		sum = 8'h00;
		for (int i = 0; i < `SLIRQ_CFG_BYTES; i++) begin
			b = (i == 13) ? sum : base + 8'(i);
			if (i == flip) b = b ^ 8'h80;
			@(posedge clk_sys);
			ilas_valid <= 1'b1;
			ilas_link <= lnk;
			ilas_lane <= lane;
			ilas_idx <= 4'(i);
			ilas_byte <= b;
			sum = sum + b;
		end
		@(posedge clk_sys);
		ilas_valid <= 1'b0;
		ilas_idx <= ~ilas_idx; // Idle lines toggle so stale data never looks valid
		ilas_byte <= ~ilas_byte;
	endtask : send
endmodule : slirq_tx_model

// file: bench/tb_top.sv
// Self-checking bench for the serial-link interrupt block
`timescale 1ns/10ps
`include "slirq_consts.svh"
module tb_top import slirq_pkg::*;;
	logic clk_sys, reset_n, reg_wr, reg_rd, ilas_valid, irq_pin_first, irq_pin_second_n;
	slirq_addr_t reg_addr;
	slirq_byte_t reg_wdata, reg_rdata, ilas_byte;
	logic [13:0] link_events;
	logic [0:0] ilas_link;
	logic [2:0] ilas_lane;
	logic [3:0] ilas_idx;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	slirq_top dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.link_events, .ilas_valid, .ilas_link, .ilas_lane, .ilas_idx, .ilas_byte,
		.irq_pin_first, .irq_pin_second_n);
	slirq_tx_model u_tx (.clk_sys, .link_events, .ilas_valid, .ilas_link, .ilas_lane,
		.ilas_idx, .ilas_byte);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input slirq_addr_t a, input slirq_byte_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input slirq_addr_t a, input slirq_byte_t exp, input string what);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(what, reg_rdata, exp);
	endtask : rd
	task automatic pins(input logic f, input logic s_n);
		repeat (2) @(posedge clk_sys);
		#1 check("pin first", irq_pin_first, f);
		check("pin second_n", irq_pin_second_n, s_n);
	endtask : pins
	task automatic close_out();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	// Reset values and an unmapped read
	task automatic t_reset();
		rd(`SLIRQ_ADDR_ST_A, 8'h00, "st_a");
		rd(`SLIRQ_ADDR_ST_B, 8'h00, "st_b");
		rd(`SLIRQ_ADDR_EN_B, 8'h00, "en_b");
		rd(`SLIRQ_ADDR_PIN_SEL, 8'h00, "pin_sel");
		rd(12'h44f, 8'h00, "unmapped");
		pins(1'b0, 1'b1);
	endtask : t_reset
	// Each of the seven link event sources of link 0 lands on its own bit and latches until written one
	task automatic t_flags();
		int pos[7] = '{0, 1, 3, 4, 5, 6, 7};
		slirq_byte_t e;
		e = 8'h00;
		wr(`SLIRQ_ADDR_EN_A, 8'hff);
		for (int k = 0; k < 7; k++) begin
			u_tx.ev(0, k);
			e[pos[k]] = 1'b1;
			rd(`SLIRQ_ADDR_ST_A, e, "st_a event");
		end
		pins(1'b1, 1'b1);
		wr(`SLIRQ_ADDR_ST_A, 8'h0f);
		rd(`SLIRQ_ADDR_ST_A, 8'hf0, "st_a w1c");
		wr(`SLIRQ_ADDR_EN_A, 8'h0f);
		pins(1'b0, 1'b1);
		wr(`SLIRQ_ADDR_ST_A, 8'hff);
		rd(`SLIRQ_ADDR_ST_A, 8'h00, "st_a clear");
	endtask : t_flags
	// Second link keeps its own flags and enables
	task automatic t_page();
		wr(`SLIRQ_ADDR_PAGE, 8'h01);
		rd(`SLIRQ_ADDR_PAGE, 8'h01, "page");
		u_tx.ev(1, 0);
		rd(`SLIRQ_ADDR_ST_A, 8'h01, "st_a link1");
		rd(`SLIRQ_ADDR_EN_A, 8'h00, "en_a link1");
		pins(1'b0, 1'b1);
		wr(`SLIRQ_ADDR_ST_A, 8'hff);
		wr(`SLIRQ_ADDR_PAGE, 8'h00);
		rd(`SLIRQ_ADDR_ST_A, 8'h00, "st_a link0");
	endtask : t_page
	// Routing to either pin
	task automatic t_route();
		u_tx.ev(0, 0);
		pins(1'b1, 1'b1);
		wr(`SLIRQ_ADDR_PIN_SEL, 8'hff);
		rd(`SLIRQ_ADDR_PIN_SEL, 8'h01, "pin_sel");
		pins(1'b0, 1'b0);
		wr(`SLIRQ_ADDR_PIN_SEL, 8'h00);
		pins(1'b1, 1'b1);
		wr(`SLIRQ_ADDR_EN_A, 8'h00);
		wr(`SLIRQ_ADDR_ST_A, 8'hff);
	endtask : t_route
	// Alignment-data compare and checksum, then the mismatch enable
	task automatic t_ilas();
		int fl[4] = '{99, 5, 13, 5};
		logic [2:0] ln[4] = '{3'h0, 3'h0, 3'h0, 3'h3};
		slirq_byte_t ea[4] = '{8'h04, 8'h04, 8'h00, 8'h00};
		slirq_byte_t eb[4] = '{8'h00, 8'h01, 8'h01, 8'h00};
		slirq_byte_t s;
		s = 8'h00;
		for (int i = 0; i < 13; i++) begin
			wr(`SLIRQ_ADDR_CFG_FIRST + 12'(i), 8'h20 + 8'(i));
			s = s + 8'h20 + 8'(i);
		end
		wr(`SLIRQ_ADDR_CFG_LAST, s);
		for (int k = 0; k < 5; k++) begin
			// Fifth pass repeats the corrupted lane-0 case so the enable has a flag to gate
			u_tx.send(1'b0, ln[(k % 4) + (k / 4)], 8'h20, fl[(k % 4) + (k / 4)]);
			repeat (3) @(posedge clk_sys);
			if (k < 4) begin
				rd(`SLIRQ_ADDR_ST_A, ea[k], "ilas st_a");
				rd(`SLIRQ_ADDR_ST_B, eb[k], "ilas st_b");
				pins(1'b0, 1'b1);
				wr(`SLIRQ_ADDR_ST_A, 8'hff);
				wr(`SLIRQ_ADDR_ST_B, 8'hff);
			end
		end
		wr(`SLIRQ_ADDR_EN_B, 8'h01);
		pins(1'b1, 1'b1);
		wr(`SLIRQ_ADDR_ST_B, 8'h01);
		pins(1'b0, 1'b1);
	endtask : t_ilas
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Watchdog on the whole run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		reset_n = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_flags();
		t_page();
		t_route();
		t_ilas();
		close_out();
	end
endmodule : tb_top

// file: hw/slirq_ilas_check.sv
// Lane-0 alignment-data checker: configuration mismatch and checksum events
`timescale 1ns/10ps
`include "slirq_consts.svh"
module slirq_ilas_check
	import slirq_pkg::*;
#(
	parameter int NUM_LINKS = 2,
	parameter int CFG_BYTES = `SLIRQ_CFG_BYTES,
	parameter int LINK_W = 1,
	parameter int LANE_W = 3,
	parameter int IDX_W = 4
)(
	input wire logic clk_sys,
	input wire logic reset_n,
	slirq_if.check chk
);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CFG_BYTES - 1);
	localparam logic [LANE_W-1:0] CHECK_LANE = LANE_W'(`SLIRQ_CHECK_LANE);

	// ----------------------------------------------------------------
	// Per-link accumulation
	// ----------------------------------------------------------------
	genvar l;
	generate
		for (l = 0; l < NUM_LINKS; l++) begin : g_link
			logic take;
			logic in_range;
			logic diff;
			logic acc_diff;
			slirq_byte_t acc_sum;

			// Other lanes carry the same data but are never looked at
			assign take = chk.ilas_valid && (chk.ilas_lane == CHECK_LANE) &&
				(chk.ilas_link == LINK_W'(l));
			assign in_range = (chk.ilas_idx <= LAST_IDX);
			// Checksum byte is compared like any other byte
			assign diff = in_range && (chk.ilas_byte != chk.expected[l][chk.ilas_idx]);

			// Bytes arrive in order; index zero restarts the accumulation
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					acc_diff <= `SLIRQ_RST_BIT;
					acc_sum <= `SLIRQ_RST_BYTE;
				end else if (take && chk.ilas_idx == '0) begin
					acc_diff <= diff;
					acc_sum <= chk.ilas_byte;
				end else if (take && chk.ilas_idx < LAST_IDX) begin
					acc_diff <= acc_diff | diff;
					acc_sum <= slirq_byte_t'(acc_sum + chk.ilas_byte);
				end
			end

			// One-cycle event pulses on the last byte
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					chk.mismatch_evt[l] <= `SLIRQ_RST_BIT;
					chk.cks_good_evt[l] <= `SLIRQ_RST_BIT;
				end else begin
					chk.mismatch_evt[l] <= take && (chk.ilas_idx == LAST_IDX) &&
						(acc_diff | diff);
					// Uses the sent checksum, never the programmed one
					chk.cks_good_evt[l] <= take && (chk.ilas_idx == LAST_IDX) &&
						(acc_sum == chk.ilas_byte);
				end
			end
		end
	endgenerate
endmodule : slirq_ilas_check

// file: hw/slirq_top.sv
// Serial-link interrupt status, enable and pin routing with paged register access
`timescale 1ns/10ps
`include "slirq_consts.svh"
// What this block does
// - Mismatch check looks at lane 0 only
// - Compare against programmed configuration bytes
// - Any differing byte, checksum included, flags mismatch
// - Enable bit 0 gates mismatch interrupt
// - Status A holds seven link event flags and the checksum flag
// - Status B bit 0 mismatch, rest reserved
// - Enables and flags per link, paged
// - Routing bit 0 picks the interrupt pin
// - Zero drives first pin, one second
// - Checksum event uses sent versus computed
module slirq_top
	import slirq_pkg::*;
#(
	parameter int NUM_LINKS = 2,
	parameter int LINK_W = 1,
	parameter int LANE_W = 3,
	parameter int IDX_W = 4
)(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire slirq_addr_t reg_addr,
	input wire slirq_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output slirq_byte_t reg_rdata,
	input wire logic [NUM_LINKS*`SLIRQ_EXT_EVENTS-1:0] link_events,
	input wire logic ilas_valid,
	input wire logic [LINK_W-1:0] ilas_link,
	input wire logic [LANE_W-1:0] ilas_lane,
	input wire logic [IDX_W-1:0] ilas_idx,
	input wire slirq_byte_t ilas_byte,
	output logic irq_pin_first,
	output logic irq_pin_second_n
);
	localparam int CFG_BYTES = `SLIRQ_CFG_BYTES;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	generate
		if (NUM_LINKS < 1 || (1 << LINK_W) < NUM_LINKS || LINK_W > 8)
			$error("slirq_top: LINK_W cannot address NUM_LINKS");
		if ((1 << IDX_W) < CFG_BYTES)
			$error("slirq_top: IDX_W too narrow for configuration bytes");
	endgenerate

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	slirq_byte_t cfg_mem [NUM_LINKS][CFG_BYTES];
	slirq_byte_t en_a [NUM_LINKS];
	logic en_b [NUM_LINKS];
	slirq_byte_t st_a [NUM_LINKS];
	logic st_b [NUM_LINKS];
	logic [NUM_LINKS-1:0] pending;
	logic [LINK_W-1:0] page;
	logic pin_sel;
	logic page_ok;
	logic hit_page;
	logic hit_cfg;
	logic hit_en_a;
	logic hit_en_b;
	logic hit_st_a;
	logic hit_st_b;
	logic hit_pin;
	slirq_addr_t cfg_off;
	logic [IDX_W-1:0] cfg_idx;
	slirq_byte_t next_rdata;

	slirq_if #(
		.NUM_LINKS(NUM_LINKS),
		.CFG_BYTES(CFG_BYTES),
		.LINK_W(LINK_W),
		.LANE_W(LANE_W),
		.IDX_W(IDX_W)
	) chk_bus ();

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// A page beyond the implemented links reaches nothing
	assign page_ok = (32'(page) < NUM_LINKS);
	assign cfg_off = reg_addr - `SLIRQ_ADDR_CFG_FIRST;
	assign cfg_idx = cfg_off[IDX_W-1:0];

	always_comb begin
		hit_page = 1'b0;
		hit_cfg = 1'b0;
		hit_en_a = 1'b0;
		hit_en_b = 1'b0;
		hit_st_a = 1'b0;
		hit_st_b = 1'b0;
		hit_pin = 1'b0;
		if (reg_addr == `SLIRQ_ADDR_PAGE) begin
			hit_page = 1'b1;
		end else if (reg_addr >= `SLIRQ_ADDR_CFG_FIRST && reg_addr <= `SLIRQ_ADDR_CFG_LAST) begin
			hit_cfg = 1'b1;
		end else if (reg_addr == `SLIRQ_ADDR_EN_A) begin
			hit_en_a = 1'b1;
		end else if (reg_addr == `SLIRQ_ADDR_EN_B) begin
			hit_en_b = 1'b1;
		end else if (reg_addr == `SLIRQ_ADDR_ST_A) begin
			hit_st_a = 1'b1;
		end else if (reg_addr == `SLIRQ_ADDR_ST_B) begin
			hit_st_b = 1'b1;
		end else if (reg_addr == `SLIRQ_ADDR_PIN_SEL) begin
			hit_pin = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Global registers: page selector and pin routing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			page <= '0;
		end else if (reg_wr && hit_page) begin
			page <= reg_wdata[LINK_W-1:0];
		end
	end

	// Reserved bits 7:1 are not stored
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_sel <= `SLIRQ_RST_BIT;
		end else if (reg_wr && hit_pin) begin
			pin_sel <= reg_wdata[`SLIRQ_BIT_PIN_SEL];
		end
	end

	// ----------------------------------------------------------------
	// Per-link copies of configuration, enables and flags
	// ----------------------------------------------------------------
	genvar l;
	generate
		for (l = 0; l < NUM_LINKS; l++) begin : g_link
			logic sel;
			logic [`SLIRQ_EXT_EVENTS-1:0] ext;
			slirq_byte_t set_a;
			slirq_byte_t clr_a;

			assign sel = page_ok && (page == LINK_W'(l));
			assign ext = link_events[l*`SLIRQ_EXT_EVENTS +: `SLIRQ_EXT_EVENTS];
			// Checksum bit comes from the local checker, the rest from the link
			assign set_a = {ext[6:2], chk_bus.cks_good_evt[l], ext[1:0]};
			assign clr_a = (reg_wr && sel && hit_st_a) ? reg_wdata : `SLIRQ_RST_BYTE;

			// Expected configuration bytes
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					for (int b = 0; b < CFG_BYTES; b++) begin
						cfg_mem[l][b] <= `SLIRQ_RST_BYTE;
					end
				end else if (reg_wr && sel && hit_cfg) begin
					cfg_mem[l][cfg_idx] <= reg_wdata;
				end
			end

			// Enables
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					en_a[l] <= `SLIRQ_RST_BYTE;
					en_b[l] <= `SLIRQ_RST_BIT;
				end else begin
					if (reg_wr && sel && hit_en_a) begin
						en_a[l] <= reg_wdata;
					end
					if (reg_wr && sel && hit_en_b) begin
						en_b[l] <= reg_wdata[`SLIRQ_BIT_MISMATCH];
					end
				end
			end

			// Sticky flags, write one to clear; a new event beats the clear
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					st_a[l] <= `SLIRQ_RST_BYTE;
					st_b[l] <= `SLIRQ_RST_BIT;
				end else begin
					st_a[l] <= (st_a[l] & ~clr_a) | set_a;
					st_b[l] <= (st_b[l] & ~(reg_wr && sel && hit_st_b &&
						reg_wdata[`SLIRQ_BIT_MISMATCH])) | chk_bus.mismatch_evt[l];
				end
			end

			assign pending[l] = (|(st_a[l] & en_a[l])) || (st_b[l] && en_b[l]);

			assign chk_bus.expected[l] = cfg_mem[l];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Alignment-data checker
	// ----------------------------------------------------------------
	assign chk_bus.ilas_valid = ilas_valid;
	assign chk_bus.ilas_link = ilas_link;
	assign chk_bus.ilas_lane = ilas_lane;
	assign chk_bus.ilas_idx = ilas_idx;
	assign chk_bus.ilas_byte = ilas_byte;

	slirq_ilas_check #(
		.NUM_LINKS(NUM_LINKS),
		.CFG_BYTES(CFG_BYTES),
		.LINK_W(LINK_W),
		.LANE_W(LANE_W),
		.IDX_W(IDX_W)
	) u_check (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.chk(chk_bus.check)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Paged reads through an unimplemented page return zero
	always_comb begin
		next_rdata = `SLIRQ_READ_ZERO;
		if (hit_page) begin
			next_rdata = 8'(page);
		end else if (hit_pin) begin
			next_rdata = {7'h00, pin_sel};
		end else if (!page_ok) begin
			next_rdata = `SLIRQ_READ_ZERO;
		end else if (hit_cfg) begin
			next_rdata = cfg_mem[page][cfg_idx];
		end else if (hit_en_a) begin
			next_rdata = en_a[page];
		end else if (hit_en_b) begin
			next_rdata = {7'h00, en_b[page]};
		end else if (hit_st_a) begin
			next_rdata = st_a[page];
		end else if (hit_st_b) begin
			next_rdata = {7'h00, st_b[page]};
		end
	end

	// Read data held until the next read
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `SLIRQ_READ_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pins
	// ----------------------------------------------------------------
	// All links share one combined request; the unselected pin stays idle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_pin_first <= `SLIRQ_RST_BIT;
			irq_pin_second_n <= `SLIRQ_RST_IRQ_N;
		end else begin
			irq_pin_first <= (|pending) && !pin_sel;
			irq_pin_second_n <= !((|pending) && pin_sel);
		end
	end
endmodule : slirq_top

// file: shared/slirq_consts.svh
// Named addresses, bit positions, reset values and counts for the serial-link IRQ block
`ifndef SLIRQ_CONSTS_SVH
`define SLIRQ_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SLIRQ_ADDR_PAGE 12'h300
`define SLIRQ_ADDR_CFG_FIRST 12'h450
`define SLIRQ_ADDR_CFG_LAST 12'h45d
`define SLIRQ_ADDR_EN_A 12'h4b8
`define SLIRQ_ADDR_EN_B 12'h4b9
`define SLIRQ_ADDR_ST_A 12'h4ba
`define SLIRQ_ADDR_ST_B 12'h4bb
`define SLIRQ_ADDR_PIN_SEL 12'h4bc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLIRQ_BIT_DISPARITY 7
`define SLIRQ_BIT_INVALID_SYM 6
`define SLIRQ_BIT_STRAY_CTRL 5
`define SLIRQ_BIT_DESKEW 4
`define SLIRQ_BIT_LANE_SYNC 3
`define SLIRQ_BIT_CHECKSUM 2
`define SLIRQ_BIT_FRAME_SYNC 1
`define SLIRQ_BIT_CGS 0
`define SLIRQ_BIT_MISMATCH 0
`define SLIRQ_BIT_PIN_SEL 0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SLIRQ_RST_BYTE 8'h00
`define SLIRQ_RST_BIT 1'b0
`define SLIRQ_RST_IRQ_N 1'b1
`define SLIRQ_READ_ZERO 8'h00
`define SLIRQ_CFG_BYTES 14
`define SLIRQ_CHECK_LANE 0
`define SLIRQ_EXT_EVENTS 7

`endif

// file: shared/slirq_if.sv
// Carrier between the register core and the lane-0 alignment-data checker
`timescale 1ns/10ps
interface slirq_if
	import slirq_pkg::*;
#(
	parameter int NUM_LINKS = 2,
	parameter int CFG_BYTES = 14,
	parameter int LINK_W = 1,
	parameter int LANE_W = 3,
	parameter int IDX_W = 4
);
	logic ilas_valid;
	logic [LINK_W-1:0] ilas_link;
	logic [LANE_W-1:0] ilas_lane;
	logic [IDX_W-1:0] ilas_idx;
	slirq_byte_t ilas_byte;
	slirq_byte_t expected [NUM_LINKS][CFG_BYTES];
	logic [NUM_LINKS-1:0] mismatch_evt;
	logic [NUM_LINKS-1:0] cks_good_evt;

	modport ctrl (
		output ilas_valid, ilas_link, ilas_lane, ilas_idx, ilas_byte, expected,
		input mismatch_evt, cks_good_evt
	);
	modport check (
		input ilas_valid, ilas_link, ilas_lane, ilas_idx, ilas_byte, expected,
		output mismatch_evt, cks_good_evt
	);
endinterface : slirq_if

// file: shared/slirq_pkg.sv
// Types shared by the serial-link IRQ block
package slirq_pkg;
	typedef logic [11:0] slirq_addr_t;
	typedef logic [7:0] slirq_byte_t;
endpackage : slirq_pkg
